// File: src/fasx_pkg.sv
// Package: constants for flash access, security and on-chip data RAM logic.
// Assumes a 100 MHz core clock and a byte-wide special-register bus.
package fasx_pkg;
    // Special-register offsets
    localparam logic [7:0] PROG_STORE_CTL_ADDR = 8'h8f;
    localparam logic [7:0] RAM_PAGE_SEL_ADDR   = 8'haf;
    localparam logic [7:0] FLASH_PRESC_ADDR    = 8'hb6;
    localparam logic [7:0] FLASH_LIMIT_ADDR    = 8'hb7;
    // Values after reset
    localparam logic [1:0] PROG_STORE_CTL_RST  = 2'h0;
    localparam logic [2:0] RAM_PAGE_SEL_RST    = 3'h0;
    localparam logic [7:0] FLASH_PRESC_RST     = 8'h8f;
    localparam logic [7:0] FLASH_LIMIT_RST     = 8'h00;
    // Field positions
    localparam int WRITE_EN_BIT   = 0;
    localparam int ERASE_EN_BIT   = 1;
    localparam int PRESC_LSB      = 0;
    localparam int PRESC_MSB      = 3;
    localparam int ONE_SHOT_BIT   = 7;
    localparam int READ_ALWAYS_BIT = 6;
    localparam logic [3:0] PRESC_DISABLED = 4'hf;
    // Flash map
    localparam logic [15:0] LOCK_WRERASE_ADDR = 16'h7dfe;
    localparam logic [15:0] LOCK_READ_ADDR    = 16'h7dff;
    localparam int SECTOR_BITS   = 9;
    localparam int BLOCK_LSB     = 12;
    localparam logic [6:0] LOCK_SECTOR = LOCK_WRERASE_ADDR[15:SECTOR_BITS];
    // On-chip data RAM
    localparam int RAM_ADDR_W = 11;
    localparam int RAM_DEPTH  = 2048;
    // Timing: prescaler is set so one tick is about 20 us
    localparam int TICK_TIME_US   = 20;
    localparam int WRITE_TIME_US  = 40;
    localparam int ERASE_TIME_US  = 10000;
    localparam int WRITE_TICKS    = (WRITE_TIME_US + TICK_TIME_US - 1)
                                    / TICK_TIME_US;
    localparam int ERASE_TICKS    = (ERASE_TIME_US + TICK_TIME_US - 1)
                                    / TICK_TIME_US;
    localparam int OP_CNT_W  = 10;
    localparam int DIV_CNT_W = 15;
endpackage

// File: src/fasx_ram.sv
// On-chip data RAM, 2048 bytes, one port.
// Assumes the caller has already folded the address to 11 bits.
`timescale 1ns/10ps
`default_nettype none
module fasx_ram
    import fasx_pkg::*;
(
    // Clock
    input  wire logic                  core_clk_i,
    // Access port
    input  wire logic                  en_i,
    input  wire logic                  we_i,
    input  wire logic [RAM_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]            wdata_i,
    output logic      [7:0]            rdata_o
);
    logic [7:0] mem [RAM_DEPTH];

    // No reset on the array; contents survive reset
    always_ff @(posedge core_clk_i) begin
        if (en_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (en_i && !we_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire

// File: src/fasx_top.sv
// Flash access control, security locks, read limit and data RAM routing.
// Assumes a CPU that stalls on cpu_stall_o and a combinational flash read.
//
// Overview of operation
// RL1: Software flash write needs write enable; erase also needs erase enable.
// RL2: Two lock bytes, each bit guarding one 4 kbyte block from debug.
// RL3: Read lock bit at zero blocks debug reads of its block.
// RL4: Write/erase lock bit cleared blocks debug writes and erases of block.
// RL5: Lock-byte sector may be written but software erase is ignored.
// RL6: Software erases a sector before writing; writes only clear bits.
// RL7: Both enables set: data write erases whole sector; data ignored.
// RL8: Addresses at or above read limit are upper partition, below lower.
// RL9: Table read from upper into lower partition returns zero.
// RL10: Upper code may execute lower code; lower code reads everything.
// RL11: Read limit is limit register in high byte, zero low byte.
// RL12: Read limit register resets to zero, everything readable.
// RL13: Read limit register takes only the first write after reset.
// RL14: Write and erase timed by hardware from 4-bit prescaler.
// RL15: Prescaler at all ones suppresses every write and erase.
// RL16: Short-address data moves take high byte from page select.
// RL17: Upper five address bits ignored; RAM repeats over 64k.
// RL18: With write enable clear, data writes go to RAM.
`timescale 1ns/10ps
`default_nettype none
module fasx_top
    import fasx_pkg::*;
#(
    parameter int ERASE_TICKS_P = ERASE_TICKS
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // Special-register bus
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // Data memory moves
    input  wire logic        dmove_req_i,
    input  wire logic        dmove_wr_i,
    input  wire logic        dmove_short_i,
    input  wire logic [15:0] dmove_addr_i,
    input  wire logic [7:0]  dmove_wdata_i,
    output logic      [7:0]  dmove_rdata_o,
    output logic             cpu_stall_o,
    // Code reads
    input  wire logic        code_rd_i,
    input  wire logic        code_table_i,
    input  wire logic [15:0] code_pc_i,
    input  wire logic [15:0] code_addr_i,
    output logic      [7:0]  code_rdata_o,
    // Debug port
    input  wire logic        dbg_rd_i,
    input  wire logic        dbg_wr_i,
    input  wire logic [15:0] dbg_addr_i,
    output logic             dbg_rd_ok_o,
    output logic             dbg_wr_ok_o,
    // Flash array
    input  wire logic [7:0]  lock_read_byte_i,
    input  wire logic [7:0]  lock_wrerase_byte_i,
    output logic      [15:0] flash_raddr_o,
    input  wire logic [7:0]  flash_rdata_i,
    output logic      [15:0] flash_addr_o,
    output logic      [7:0]  flash_wdata_o,
    output logic             flash_write_o,
    output logic             flash_erase_o
);
    typedef enum logic {FLS_IDLE, FLS_BUSY} fasx_fls_t;

    logic [1:0]           prog_ctl_reg;
    logic [2:0]           page_sel_reg;
    logic [7:0]           presc_reg;
    logic [7:0]           limit_reg;
    logic                 limit_taken_reg;
    fasx_fls_t            fls_state_reg;
    logic [DIV_CNT_W-1:0] div_cnt_reg;
    logic [OP_CNT_W-1:0]  op_cnt_reg;
    logic [15:0]          read_limit;
    logic [15:0]          dmove_full;
    logic [3:0]           presc;
    logic                 fls_start;
    logic                 fls_erase_req;
    logic                 tick;
    logic                 ram_en;
    logic                 ram_we;
    logic                 code_blocked;

    // Returns one where the lock byte leaves the block open
    function automatic logic lock_open(input logic [7:0] lock_byte,
                                       input logic [15:0] addr);
        // One lock bit per 4 kbyte block; upper space is never locked
        return addr[15] ? 1'b1 : lock_byte[addr[14:BLOCK_LSB]]; // [RL2]
    endfunction
    function automatic logic sfr_hit(input logic [7:0] addr,
                                     input logic [7:0] target);
        return addr == target;
    endfunction

    // Register writes
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_ctl_reg <= PROG_STORE_CTL_RST;
            page_sel_reg <= RAM_PAGE_SEL_RST;
            presc_reg    <= FLASH_PRESC_RST;
        end else if (sfr_wr_i) begin
            if (sfr_hit(sfr_addr_i, PROG_STORE_CTL_ADDR)) begin
                prog_ctl_reg <= sfr_wdata_i[1:0];
            end
            if (sfr_hit(sfr_addr_i, RAM_PAGE_SEL_ADDR)) begin
                page_sel_reg <= sfr_wdata_i[2:0];
            end
            if (sfr_hit(sfr_addr_i, FLASH_PRESC_ADDR)) begin
                presc_reg <= {sfr_wdata_i[7:6], 2'h0, sfr_wdata_i[3:0]};
            end
        end
    end

    // Read limit locks after its first write until reset
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            limit_reg       <= FLASH_LIMIT_RST;                // [RL12]
            limit_taken_reg <= 1'b0;
        end else if (sfr_wr_i && !limit_taken_reg &&
                     sfr_hit(sfr_addr_i, FLASH_LIMIT_ADDR)) begin
            limit_reg       <= sfr_wdata_i;                    // [RL13]
            limit_taken_reg <= 1'b1;
        end
    end
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                PROG_STORE_CTL_ADDR: sfr_rdata_o <= {6'h00, prog_ctl_reg};
                RAM_PAGE_SEL_ADDR:   sfr_rdata_o <= {5'h00, page_sel_reg};
                FLASH_PRESC_ADDR:    sfr_rdata_o <= presc_reg;
                FLASH_LIMIT_ADDR:    sfr_rdata_o <= limit_reg;
                default:             sfr_rdata_o <= 8'h00;
            endcase
        end
    end
    // Partition split on 256-byte steps
    assign read_limit = {limit_reg, 8'h00};                     // [RL11]
    // Only table reads are checked, so plain fetches run anywhere
    assign code_blocked = code_table_i &&                       // [RL10]
                          (code_pc_i >= read_limit) &&          // [RL8]
                          (code_addr_i < read_limit);
    assign flash_raddr_o = code_addr_i;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            code_rdata_o <= 8'h00;
        end else if (code_rd_i) begin
            code_rdata_o <= code_blocked ? 8'h00 : flash_rdata_i; // [RL9]
        end
    end
    // Debug port gating by lock bytes
    assign dbg_rd_ok_o = dbg_rd_i &&
                         lock_open(lock_read_byte_i, dbg_addr_i);   // [RL3]
    assign dbg_wr_ok_o = dbg_wr_i &&
                         lock_open(lock_wrerase_byte_i, dbg_addr_i); // [RL4]
    // Data moves: address forming and routing
    assign dmove_full = dmove_short_i
                        ? {5'h00, page_sel_reg, dmove_addr_i[7:0]}
                        : dmove_addr_i;                         // [RL16]
    assign presc = presc_reg[PRESC_MSB:PRESC_LSB];
    assign fls_erase_req = prog_ctl_reg[ERASE_EN_BIT];
    // CPU is held while busy, so no request is taken then
    assign fls_start = dmove_req_i && dmove_wr_i &&
                       prog_ctl_reg[WRITE_EN_BIT] &&            // [RL1]
                       (presc != PRESC_DISABLED) &&             // [RL15]
                       (fls_state_reg == FLS_IDLE) &&
                       !(fls_erase_req &&
                         dmove_full[15:SECTOR_BITS] == LOCK_SECTOR); // [RL5]
    assign ram_en = dmove_req_i &&
                    !(dmove_wr_i && prog_ctl_reg[WRITE_EN_BIT]);
    assign ram_we = ram_en && dmove_wr_i;                       // [RL18]
    assign cpu_stall_o = (fls_state_reg == FLS_BUSY);
    fasx_ram u_ram (
        .core_clk_i (core_clk_i),
        .en_i       (ram_en),
        .we_i       (ram_we),
        .addr_i     (dmove_full[RAM_ADDR_W-1:0]),               // [RL17]
        .wdata_i    (dmove_wdata_i),
        .rdata_o    (dmove_rdata_o)
    );
    // Tick about every 20 us when prescaler matches the clock
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_reg <= '0;
        end else if (fls_start || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end
    assign tick = (fls_state_reg == FLS_BUSY) &&
                  (div_cnt_reg >= ((DIV_CNT_W'(1) << presc) -
                                   DIV_CNT_W'(1)));             // [RL14]
    // Operation sequencer; no polling, the CPU just stalls
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fls_state_reg <= FLS_IDLE;
            op_cnt_reg    <= '0;
            flash_addr_o  <= 16'h0000;
            flash_wdata_o <= 8'h00;
            flash_write_o <= 1'b0;
            flash_erase_o <= 1'b0;
        end else begin
            case (fls_state_reg)
                FLS_IDLE: begin
                    if (fls_start) begin
                        fls_state_reg <= FLS_BUSY;
                        flash_addr_o  <= dmove_full;
                        // Array only clears bits on a write
                        flash_wdata_o <= fls_erase_req ? 8'hff
                                                       : dmove_wdata_i; // [RL7]
                        flash_erase_o <= fls_erase_req;         // [RL7]
                        flash_write_o <= !fls_erase_req;
                        op_cnt_reg    <= fls_erase_req
                                         ? OP_CNT_W'(ERASE_TICKS_P)
                                         : OP_CNT_W'(WRITE_TICKS); // [RL14]
                    end
                end
                FLS_BUSY: begin
                    if (tick) begin
                        if (op_cnt_reg == OP_CNT_W'(1)) begin
                            fls_state_reg <= FLS_IDLE;
                            flash_write_o <= 1'b0;
                            flash_erase_o <= 1'b0;
                        end
                        op_cnt_reg <= op_cnt_reg - 1'b1;
                    end
                end
                default: fls_state_reg <= FLS_IDLE;
            endcase
        end
    end
    property p_write_needs_enable;
        @(posedge core_clk_i) disable iff (!resetn_i)
        $rose(flash_write_o) |-> $past(prog_ctl_reg[WRITE_EN_BIT]);
    endproperty
    a_write_needs_enable: assert property (p_write_needs_enable) // [RL1]
        else $error("flash write without write enable");
    property p_erase_needs_both;
        @(posedge core_clk_i) disable iff (!resetn_i)
        $rose(flash_erase_o) |-> $past(prog_ctl_reg) == 2'b11;
    endproperty
    a_erase_needs_both: assert property (p_erase_needs_both) // [RL7]
        else $error("flash erase without both enables");
    property p_lock_sector_kept;
        @(posedge core_clk_i) disable iff (!resetn_i)
        flash_erase_o |-> flash_addr_o[15:SECTOR_BITS] != LOCK_SECTOR;
    endproperty
    a_lock_sector_kept: assert property (p_lock_sector_kept) // [RL5]
        else $error("lock sector erased by software");
    property p_dbg_read_lock;
        @(posedge core_clk_i) disable iff (!resetn_i)
        !dbg_addr_i[15] && !lock_read_byte_i[dbg_addr_i[14:BLOCK_LSB]]
            |-> !dbg_rd_ok_o;
    endproperty
    a_dbg_read_lock: assert property (p_dbg_read_lock) // [RL3]
        else $error("debug read of locked block");
    property p_dbg_write_lock;
        @(posedge core_clk_i) disable iff (!resetn_i)
        !dbg_addr_i[15] && !lock_wrerase_byte_i[dbg_addr_i[14:BLOCK_LSB]]
            |-> !dbg_wr_ok_o;
    endproperty
    a_dbg_write_lock: assert property (p_dbg_write_lock) // [RL4]
        else $error("debug write of locked block");
    property p_table_read_zero;
        @(posedge core_clk_i) disable iff (!resetn_i)
        code_rd_i && code_table_i && code_pc_i >= {limit_reg, 8'h00} &&
            code_addr_i < {limit_reg, 8'h00} |=> code_rdata_o == 8'h00;
    endproperty
    a_table_read_zero: assert property (p_table_read_zero) // [RL9]
        else $error("upper table read saw lower data");
    property p_limit_once;
        @(posedge core_clk_i) disable iff (!resetn_i)
        limit_taken_reg |=> $stable(limit_reg) && limit_taken_reg;
    endproperty
    a_limit_once: assert property (p_limit_once) // [RL13]
        else $error("read limit changed after first write");
    property p_presc_off;
        @(posedge core_clk_i) disable iff (!resetn_i)
        presc == PRESC_DISABLED && fls_state_reg == FLS_IDLE
            |=> !flash_write_o && !flash_erase_o;
    endproperty
    a_presc_off: assert property (p_presc_off) // [RL15]
        else $error("flash op started with prescaler off");
    property p_ram_route;
        @(posedge core_clk_i) disable iff (!resetn_i)
        dmove_req_i && dmove_wr_i && !prog_ctl_reg[WRITE_EN_BIT]
            |-> ram_we && !fls_start;
    endproperty
    a_ram_route: assert property (p_ram_route) // [RL18]
        else $error("data write not routed to RAM");
endmodule
`default_nettype wire

// File: dv/fasx_flash_model.sv
// Flash array model: byte store, lock bytes, byte write and sector erase.
// Assumes write and erase strobes are levels held for each operation.
`timescale 1ns/10ps
`default_nettype none
module fasx_flash_model (
    // Clock
    input  wire logic        core_clk_i,
    // Array access
    input  wire logic [15:0] raddr_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        write_i,
    input  wire logic        erase_i,
    // Lock bytes
    output logic      [7:0]  lock_read_o,
    output logic      [7:0]  lock_wrerase_o
);
    logic [7:0] mem [0:65535];
    logic       busy_q;
    initial begin
        busy_q = 1'b0;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i ^ (i >> 8));
    end
    assign rdata_o        = mem[raddr_i];
    assign lock_read_o    = mem[16'h7dff];
    assign lock_wrerase_o = mem[16'h7dfe];
    // Applied at op start; the core stays stalled until the op ends
    always @(posedge core_clk_i) begin
        busy_q <= write_i | erase_i;
        if (write_i && !busy_q)
            mem[addr_i] <= mem[addr_i] & wdata_i;
        if (erase_i && !busy_q)
            for (int i = 0; i < 512; i++)
                mem[{addr_i[15:9], 9'(i)}] <= 8'hff;
    end
endmodule
`default_nettype wire

// File: dv/fasx_tb_top.sv
// Bench: registers, read limit, debug locks, data RAM and flash operations.
// Assumes the package and the flash model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module flash_access_security_on_chip_data_ram_tb_top;
    import fasx_pkg::*;
    localparam int ETICKS = 3;
    logic        core_clk_i = 1'b0, resetn_i = 1'b0;
    logic        sfr_wr_i = 0, sfr_rd_i = 0, dmove_req_i = 0, dmove_wr_i = 0;
    logic        dmove_short_i = 0, code_rd_i = 0, code_table_i = 0;
    logic        dbg_rd_i = 0, dbg_wr_i = 0, s;
    logic [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, dmove_wdata_i = 0;
    logic [15:0] dmove_addr_i = 0, code_pc_i = 0, code_addr_i = 0;
    logic [15:0] dbg_addr_i = 0, lim = 0, a, f;
    logic [7:0]  sfr_rdata_o, dmove_rdata_o, code_rdata_o, flash_wdata_o;
    logic [7:0]  lock_read_byte_i, lock_wrerase_byte_i, flash_rdata_i;
    logic [15:0] flash_raddr_o, flash_addr_o;
    logic        cpu_stall_o, dbg_rd_ok_o, dbg_wr_ok_o;
    logic        flash_write_o, flash_erase_o;
    int          fail_count = 0, checks = 0, cyc = 0, ram [0:2047];
    logic [7:0]  fx [int];
    logic [31:0] seed = 32'h2693;
    logic [7:0]  ps = 0, rd, pg, d;
    logic [7:0]  ra [5] = '{8'h8f, 8'haf, 8'hb6, 8'hb7, 8'h90};
    logic [7:0]  rv [5] = '{8'h00, 8'h00, 8'h8f, 8'h00, 8'h00};
    logic [7:0]  wd [5] = '{8'hff, 8'hff, 8'hff, 8'h40, 8'hff};
    logic [7:0]  wv [5] = '{8'h03, 8'h07, 8'hcf, 8'h40, 8'h00};

    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            test_done();
        end
    end

    fasx_top #(.ERASE_TICKS_P(ETICKS)) dut (.core_clk_i, .resetn_i,
        .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o,
        .dmove_req_i, .dmove_wr_i, .dmove_short_i, .dmove_addr_i,
        .dmove_wdata_i, .dmove_rdata_o, .cpu_stall_o, .code_rd_i,
        .code_table_i, .code_pc_i, .code_addr_i, .code_rdata_o, .dbg_rd_i,
        .dbg_wr_i, .dbg_addr_i,
        .dbg_rd_ok_o, .dbg_wr_ok_o, .lock_read_byte_i, .lock_wrerase_byte_i,
        .flash_raddr_o, .flash_rdata_i, .flash_addr_o, .flash_wdata_o,
        .flash_write_o, .flash_erase_o);
    fasx_flash_model flash (.core_clk_i, .raddr_i(flash_raddr_o),
        .rdata_o(flash_rdata_i), .addr_i(flash_addr_o),
        .wdata_i(flash_wdata_o), .write_i(flash_write_o),
        .erase_i(flash_erase_o), .lock_read_o(lock_read_byte_i),
        .lock_wrerase_o(lock_wrerase_byte_i));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] fget(input logic [15:0] x);
        return fx.exists(x) ? fx[x] : 8'(x ^ (x >> 8));
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sfr(input logic w, input logic [7:0] ad, dt);
        @(negedge core_clk_i);
        {sfr_wr_i, sfr_rd_i, sfr_addr_i, sfr_wdata_i} = {w, !w, ad, dt};
        @(negedge core_clk_i);
        {sfr_wr_i, sfr_rd_i} = 2'b00;
        rd = sfr_rdata_o;
    endtask
    task automatic mv(input logic w, sh, input logic [15:0] ad,
                      input logic [7:0] dt);
        @(negedge core_clk_i);
        {dmove_req_i, dmove_wr_i, dmove_short_i} = {1'b1, w, sh};
        {dmove_addr_i, dmove_wdata_i} = {ad, dt};
        @(negedge core_clk_i);
        dmove_req_i = 1'b0;
        rd = dmove_rdata_o;
    endtask
    task automatic cr(input logic [15:0] pc, ad, input logic t);
        @(negedge core_clk_i);
        {code_rd_i, code_pc_i, code_addr_i, code_table_i} = {1'b1, pc, ad, t};
        @(negedge core_clk_i);
        code_rd_i = 1'b0;
        chk(code_rdata_o, (t && pc >= lim && ad < lim) ? 8'h00 : fget(ad));
    endtask
    task automatic dbg(input logic [15:0] ad);
        logic [7:0] lr, lw;
        lr = fget(16'h7dff);
        lw = fget(16'h7dfe);
        @(negedge core_clk_i);
        {dbg_rd_i, dbg_wr_i, dbg_addr_i} = {2'b11, ad};
        #1;
        chk(dbg_rd_ok_o, ad[15] | lr[ad[14:12]]);
        chk(dbg_wr_ok_o, ad[15] | lw[ad[14:12]]);
    endtask
    // Software flash op; dur is the expected stall length, 0 when dropped
    task automatic fop(input logic [15:0] ad, input logic [7:0] dt,
                       input int dur);
        int n;
        logic e;
        e = ps[1];
        n = 0;
        mv(1'b1, 1'b0, ad, dt);
        if (dur > 0) begin
            chk(flash_addr_o, ad);
            chk({flash_erase_o, flash_write_o}, {e, !e});
            chk(flash_wdata_o, e ? 8'hff : dt);
        end
        while (cpu_stall_o === 1'b1 && n < 5000) begin
            n++;
            @(negedge core_clk_i);
        end
        chk(16'(n), 16'(dur));
        if (dur > 0 && e)
            for (int i = 0; i < 512; i++)
                fx[{ad[15:9], 9'(i)}] = 8'hff;
        else if (dur > 0)
            fx[ad] = fget(ad) & dt;
        @(negedge core_clk_i);
    endtask
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        resetn_i = 1'b1;
        foreach (ra[i]) begin
            sfr(1'b0, ra[i], 8'h00);
            chk(rd, rv[i]);
        end
        cr(16'hffff, 16'h0000, 1'b1);
        foreach (ra[i]) begin
            sfr(1'b1, ra[i], wd[i]);
            sfr(1'b0, ra[i], 8'h00);
            chk(rd, wv[i]);
        end
        lim = 16'h4000;
        sfr(1'b1, 8'hb7, 8'h10);
        sfr(1'b0, 8'hb7, 8'h00);
        chk(rd, 8'h40);
        sfr(1'b1, 8'h8f, 8'h00);
        // Limit edges first, then random pc and address pairs
        cr(16'h4000, 16'h3fff, 1'b1);
        cr(16'h3fff, 16'h0000, 1'b1);
        cr(16'h4000, 16'h4000, 1'b1);
        cr(16'h4000, 16'h0000, 1'b0);
        for (int i = 0; i < 20; i++)
            cr(16'(rnd()), 16'(rnd()) & 16'h7fff, 1'(rnd()));
        for (int i = 0; i < 12; i++)
            dbg(16'(rnd()));
        // Erase enable alone must still leave data writes on the RAM
        sfr(1'b1, 8'h8f, 8'h02);
        for (int i = 0; i < 12; i++) begin
            pg = 8'(rnd());
            a = 16'(rnd());
            d = 8'(rnd());
            s = a[15];
            sfr(1'b1, 8'haf, pg);
            f = s ? {5'h00, pg[2:0], a[7:0]} : a;
            mv(1'b1, s, a, d);
            chk(cpu_stall_o, 1'b0);
            ram[f[10:0]] = d;
            mv(1'b0, 1'b0, f ^ (16'(rnd()) & 16'hf800), 8'h00);
            chk(rd, 16'(ram[f[10:0]]));
        end
        sfr(1'b1, 8'h8f, 8'h01);
        ps = 8'h01;
        mv(1'b1, 1'b0, 16'h0234, 8'h00);
        fop(16'h1234, 8'h00, 0);
        sfr(1'b0, 8'h8f, 8'h00);
        chk(rd, 8'h01);
        cr(16'h0000, 16'h1234, 1'b0);
        sfr(1'b1, 8'hb6, 8'h01);
        sfr(1'b1, 8'h8f, 8'h03);
        ps = 8'h03;
        fop(16'h1200, 8'h5a, ETICKS * 2);
        cr(16'h0000, 16'h1210, 1'b0);
        sfr(1'b1, 8'h8f, 8'h01);
        ps = 8'h01;
        for (int p = 0; p < 3; p++) begin
            sfr(1'b1, 8'hb6, 8'(p));
            fop(16'h1234 + 16'(p), 8'(rnd()), 2 << p);
            cr(16'h0000, 16'h1234 + 16'(p), 1'b0);
        end
        sfr(1'b1, 8'h8f, 8'h03);
        ps = 8'h03;
        fop(16'h7c10, 8'h00, 0);
        cr(16'h0000, 16'h7c10, 1'b0);
        sfr(1'b1, 8'h8f, 8'h01);
        ps = 8'h01;
        fop(16'h7dfe, 8'h01, 8);
        dbg(16'h1000);
        dbg(16'h0000);
        dbg(16'h9000);
        // Second reset must reopen the read limit for one write
        @(negedge core_clk_i);
        resetn_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        resetn_i = 1'b1;
        sfr(1'b0, 8'hb7, 8'h00);
        chk(rd, 8'h00);
        sfr(1'b1, 8'hb7, 8'h20);
        sfr(1'b1, 8'hb7, 8'h30);
        sfr(1'b0, 8'hb7, 8'h00);
        chk(rd, 8'h20);
        lim = 16'h2000;
        cr(16'h2000, 16'h1000, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
